// >>> port_a_mux_pkg.sv
// constants for the port a pin function multiplexer
// assumes a single 250 mhz clock and a synchronous active-high reset
package port_a_mux_pkg;
  localparam int          PIN_COUNT     = 8;
  localparam int          PIN_DAC       = 2;
  localparam int          PIN_CCP       = 4;
  localparam int          PIN_SR        = 5;
  localparam int          PIN_OSC_OUT   = 6;
  localparam int          PIN_OSC_IN    = 7;
  localparam logic [7:0]  ANALOG_CAPABLE = 8'h2F;
  localparam logic [7:0]  DIR_RESET     = 8'hFF;
  localparam logic [7:0]  LATCH_RESET   = 8'h00;
  localparam int          CLK_DIV_RATIO = 4;
  localparam logic [1:0]  CLK_DIV_LAST  = 2'(CLK_DIV_RATIO - 1);
  localparam logic [1:0]  CLK_DIV_HALF  = 2'(CLK_DIV_RATIO / 2);
  // oscillator mode selection
  typedef enum logic [1:0] {
    OSC_INTERNAL,
    OSC_RC,
    OSC_CRYSTAL,
    OSC_EXT_CLOCK
  } osc_mode_t;
endpackage : port_a_mux_pkg

// >>> port_a_pin_function_mux.sv
// port a pin function multiplexer: latch, digital input, analog routing, peripheral outputs
// assumes peripheral outputs and configuration come from logic on sys_clk_in; pin inputs are asynchronous
// Function
// - direction 0 and analog 0: pin driven from its output latch bit
// - direction 1, analog 0: pin read via input buffer; analog disables it
// - analog functions on pins 0,1,2,3,5 routed only when direction and analog are 1
// - pin 2 dac output needs analog 1, disables latch drive and digital input
// - pin 4 has no analog select, schmitt input, powers up as input
// - pin 4 capture_compare_pwm_unit_5 output overrides latch; as input it feeds capture 5
// - pin 4 sr latch true output beats capture_compare_pwm_unit_5 output when enabled, direction 0
// - pin 4 input with direction 1 drives timer 0 external clock
// - pin 5 offers comparator 2 and inverted sr outputs; input feeds slave select
// - pin 6 is port i/o only in internal oscillator mode without clock output
// - rc mode: pin 6 outputs quarter-rate clock, direction bit ignored
// - pin 7 port i/o disabled in external oscillator modes; carries clock input
// - pin 7 schmitt buffer in rc mode, cmos otherwise; clock input passed on only in external oscillator modes
// - several enabled outputs: fixed per-pin priority picks the driver
// - analog inputs skip output priority; digital outputs may drive analog pins
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module port_a_pin_function_mux (
  input  wire logic                     sys_clk_in,
  input  wire logic                     reset_in,
  input  wire logic [2:0]               reg_addr_in,
  input  wire logic [7:0]               reg_wdata_in,
  input  wire logic                     reg_write_in,
  input  wire logic                     reg_read_in,
  output logic      [7:0]               reg_rdata_out,
  input  wire logic [7:0]               pin_level_in,
  output logic      [7:0]               pin_drive_out,
  output logic      [7:0]               pin_oe_out,
  output logic      [7:0]               analog_route_out,
  input  wire logic                     capture_compare_pwm_unit_5_out_in,
  input  wire logic                     capture_compare_pwm_unit_5_out_en_in,
  output logic                          capture_compare_pwm_unit_5_capture_out,
  input  wire logic                     sr_latch_true_out_in,
  input  wire logic                     sr_latch_true_en_in,
  input  wire logic                     sr_latch_inverted_out_in,
  input  wire logic                     sr_latch_inverted_en_in,
  input  wire logic                     comparator_one_output_in,
  input  wire logic                     comparator_one_en_in,
  input  wire logic                     comparator_two_output_in,
  input  wire logic                     comparator_two_en_in,
  input  wire logic                     dac_reference_output_en_in,
  output logic                          timer_zero_ext_clock_out,
  output logic                          serial_port_one_slave_select_out,
  output logic                          external_clock_input_out,
  output logic                          osc_in_schmitt_out,
  output logic                          quarter_rate_clock_out
);

  // register map: 0 latch, 1 direction, 2 analog select, 3 mode, 4 pin read
  localparam logic [2:0] ADDR_LATCH  = 3'h0;
  localparam logic [2:0] ADDR_DIR    = 3'h1;
  localparam logic [2:0] ADDR_ANALOG_SELECT_BIT  = 3'h2;
  localparam logic [2:0] ADDR_MODE   = 3'h3;
  localparam logic [2:0] ADDR_READ   = 3'h4;

  logic [7:0] port_output_latch_r;
  logic [7:0] direction_bit_r;
  logic [7:0] analog_select_bit_r;
  port_a_mux_pkg::osc_mode_t osc_mode_r;
  logic       clock_output_function_r;
  logic [7:0] pin_sync1_r;
  logic [7:0] pin_sync2_r;
  logic [1:0] div_cnt_r;
  logic       quarter_clk_r;
  logic [7:0] port_pin_read;
  logic [7:0] dig_in_en;
  logic [7:0] analog_select_bit_eff;
  logic [7:0] drive_nxt;
  logic [7:0] oe_nxt;
  logic       osc_int;
  logic       osc_rc;
  logic       osc_ext;
  logic       pin6_port;
  logic       dac_on;

  // latch keeps its value whatever the pin direction or analog mode
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      port_output_latch_r <= port_a_mux_pkg::LATCH_RESET;
    end else if (reg_write_in && reg_addr_in == ADDR_LATCH) begin
      port_output_latch_r <= reg_wdata_in;
    end
  end

  // all pins come up as inputs so nothing drives the board before software
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      direction_bit_r <= port_a_mux_pkg::DIR_RESET;
    end else if (reg_write_in && reg_addr_in == ADDR_DIR) begin
      direction_bit_r <= reg_wdata_in;
    end
  end

  // pins without analog capability keep the select bit at zero
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      analog_select_bit_r <= port_a_mux_pkg::ANALOG_CAPABLE;
    end else if (reg_write_in && reg_addr_in == ADDR_ANALOG_SELECT_BIT) begin
      analog_select_bit_r <= reg_wdata_in & port_a_mux_pkg::ANALOG_CAPABLE;
    end
  end

  // mode and clock-output bits share one register address
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      osc_mode_r <= port_a_mux_pkg::OSC_INTERNAL;
    end else if (reg_write_in && reg_addr_in == ADDR_MODE) begin
      osc_mode_r <= port_a_mux_pkg::osc_mode_t'(reg_wdata_in[1:0]);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      clock_output_function_r <= 1'b0;
    end else if (reg_write_in && reg_addr_in == ADDR_MODE) begin
      clock_output_function_r <= reg_wdata_in[2];
    end
  end

  // two-stage synchroniser for asynchronous pin levels
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pin_sync1_r <= 8'h00;
      pin_sync2_r <= 8'h00;
    end else begin
      pin_sync1_r <= pin_level_in;
      pin_sync2_r <= pin_sync1_r;
    end
  end

  // read data stands until the next read strobe
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        ADDR_LATCH: reg_rdata_out <= port_output_latch_r;
        ADDR_DIR:   reg_rdata_out <= direction_bit_r;
        ADDR_ANALOG_SELECT_BIT: reg_rdata_out <= analog_select_bit_r;
        ADDR_MODE:  reg_rdata_out <= {5'h00, clock_output_function_r, osc_mode_r};
        ADDR_READ:  reg_rdata_out <= port_pin_read;
        default:    reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // rc oscillator instruction-rate clock, derived from the system clock
  // since the oscillator input itself is not a clock domain here
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      div_cnt_r <= 2'h0;
    end else begin
      div_cnt_r <= (div_cnt_r == port_a_mux_pkg::CLK_DIV_LAST) ? 2'h0 : div_cnt_r + 2'h1;
    end
  end

  // high for the first half of each count: two cycles up, two down
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      quarter_clk_r <= 1'b0;
    end else begin
      quarter_clk_r <= (div_cnt_r < port_a_mux_pkg::CLK_DIV_HALF);
    end
  end

  // rc counts as external: pin 7 then carries the rc network
  always_comb begin
    osc_int   = (osc_mode_r == port_a_mux_pkg::OSC_INTERNAL);
    osc_rc    = (osc_mode_r == port_a_mux_pkg::OSC_RC);
    osc_ext   = !osc_int;
    pin6_port = osc_int && !clock_output_function_r;
    dac_on    = dac_reference_output_en_in && analog_select_bit_r[port_a_mux_pkg::PIN_DAC];
    analog_select_bit_eff = analog_select_bit_r & port_a_mux_pkg::ANALOG_CAPABLE;
  end

  always_comb begin
    dig_in_en = ~analog_select_bit_eff;
    if (dac_on) begin
      dig_in_en[port_a_mux_pkg::PIN_DAC] = 1'b0;
    end
    // oscillator pads must not leak clock swing into the read path
    dig_in_en[port_a_mux_pkg::PIN_OSC_OUT] = pin6_port;
    dig_in_en[port_a_mux_pkg::PIN_OSC_IN]  = !osc_ext;
    port_pin_read = pin_sync2_r & dig_in_en;
  end

  // latch drive is independent of analog select, then peripherals override
  always_comb begin
    drive_nxt = port_output_latch_r;
    oe_nxt    = ~direction_bit_r;
    if (dac_on) begin
      oe_nxt[port_a_mux_pkg::PIN_DAC] = 1'b0;
    end
    // pin 4 priority: sr true, comparator 1, capture_compare_pwm_unit_5, latch
    if (!direction_bit_r[port_a_mux_pkg::PIN_CCP]) begin
      if (sr_latch_true_en_in) begin
        drive_nxt[port_a_mux_pkg::PIN_CCP] = sr_latch_true_out_in;
      end else if (comparator_one_en_in) begin
        drive_nxt[port_a_mux_pkg::PIN_CCP] = comparator_one_output_in;
      end else if (capture_compare_pwm_unit_5_out_en_in) begin
        drive_nxt[port_a_mux_pkg::PIN_CCP] = capture_compare_pwm_unit_5_out_in;
      end
    end
    // pin 5 priority: sr inverted, comparator 2, latch
    if (!direction_bit_r[port_a_mux_pkg::PIN_SR]) begin
      if (sr_latch_inverted_en_in) begin
        drive_nxt[port_a_mux_pkg::PIN_SR] = sr_latch_inverted_out_in;
      end else if (comparator_two_en_in) begin
        drive_nxt[port_a_mux_pkg::PIN_SR] = comparator_two_output_in;
      end
    end
    // pin 6: quarter-rate clock ignores direction; other modes release the pin unless it is port i/o
    if (osc_rc) begin
      drive_nxt[port_a_mux_pkg::PIN_OSC_OUT] = quarter_clk_r;
      oe_nxt[port_a_mux_pkg::PIN_OSC_OUT]    = 1'b1;
    end else if (!pin6_port) begin
      oe_nxt[port_a_mux_pkg::PIN_OSC_OUT]    = 1'b0;
    end
    if (osc_ext) begin
      oe_nxt[port_a_mux_pkg::PIN_OSC_IN] = 1'b0;
    end
  end

  // outputs registered so a peripheral glitch never reaches a pad
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pin_drive_out <= 8'h00;
    end else begin
      pin_drive_out <= drive_nxt;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pin_oe_out <= 8'h00;
    end else begin
      pin_oe_out <= oe_nxt;
    end
  end

  // analog paths open only on capable pins set as inputs
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      analog_route_out <= 8'h00;
    end else begin
      analog_route_out <= direction_bit_r & analog_select_bit_eff;
    end
  end

  // capture and timer clock share the one synchronised pin 4 level
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      capture_compare_pwm_unit_5_capture_out <= 1'b0;
    end else begin
      capture_compare_pwm_unit_5_capture_out <= direction_bit_r[port_a_mux_pkg::PIN_CCP] &
                          pin_sync2_r[port_a_mux_pkg::PIN_CCP];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      timer_zero_ext_clock_out <= 1'b0;
    end else begin
      timer_zero_ext_clock_out <= direction_bit_r[port_a_mux_pkg::PIN_CCP] &
                                  pin_sync2_r[port_a_mux_pkg::PIN_CCP];
    end
  end

  // slave select takes the gated read, so analog mode holds it low
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      serial_port_one_slave_select_out <= 1'b0;
    end else begin
      serial_port_one_slave_select_out <= direction_bit_r[port_a_mux_pkg::PIN_SR] &
                                          port_pin_read[port_a_mux_pkg::PIN_SR];
    end
  end

  // only passed on while the pin 7 pad belongs to the oscillator
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      external_clock_input_out <= 1'b0;
    end else begin
      external_clock_input_out <= osc_ext & pin_sync2_r[port_a_mux_pkg::PIN_OSC_IN];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      osc_in_schmitt_out <= 1'b0;
    end else begin
      osc_in_schmitt_out <= osc_rc;
    end
  end

  assign quarter_rate_clock_out = quarter_clk_r;

endmodule : port_a_pin_function_mux
`default_nettype wire

// >>> port_a_mux_chk.sv
// concurrent checks on the port a pin multiplexer ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module port_a_mux_chk (
  input wire logic       sys_clk_in,
  input wire logic       reset_in,
  input wire logic       reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [7:0] pin_drive_out,
  input wire logic [7:0] pin_oe_out,
  input wire logic [7:0] analog_route_out,
  input wire logic       sr_latch_true_out_in,
  input wire logic       sr_latch_true_en_in,
  input wire logic       sr_latch_inverted_out_in,
  input wire logic       sr_latch_inverted_en_in,
  input wire logic       capture_compare_pwm_unit_5_capture_out,
  input wire logic       timer_zero_ext_clock_out,
  input wire logic       osc_in_schmitt_out,
  input wire logic       quarter_rate_clock_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  property p_rd_hold;
    !$past(reg_read_in) |-> $stable(reg_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_oe_boot;
    $fell(reset_in) |-> (pin_oe_out == 8'h00) [*2];
  endproperty
  a_oe_boot: assert property (p_oe_boot) else $error("pins not inputs after reset");
  property p_route;
    (analog_route_out & ~port_a_mux_pkg::ANALOG_CAPABLE) == 8'h00;
  endproperty
  a_route: assert property (p_route) else $error("analog on digital-only pin");
  property p_t0;
    capture_compare_pwm_unit_5_capture_out == timer_zero_ext_clock_out && !(pin_oe_out[4] && capture_compare_pwm_unit_5_capture_out);
  endproperty
  a_t0: assert property (p_t0) else $error("pin 4 inputs disagree");
  property p_qclk;
    $rose(quarter_rate_clock_out) |=> quarter_rate_clock_out ##1 !quarter_rate_clock_out [*2] ##1
      quarter_rate_clock_out;
  endproperty
  a_qclk: assert property (p_qclk) else $error("quarter clock shape");
  property p_sr4;
    $past(sr_latch_true_en_in) && pin_oe_out[4] |-> pin_drive_out[4] == $past(sr_latch_true_out_in);
  endproperty
  a_sr4: assert property (p_sr4) else $error("pin 4 not from sr latch");
  property p_sr5;
    $past(sr_latch_inverted_en_in) && pin_oe_out[5] |-> pin_drive_out[5] == $past(sr_latch_inverted_out_in);
  endproperty
  a_sr5: assert property (p_sr5) else $error("pin 5 not from sr latch");
  // two samples so a one-cycle skew between the flops cannot fire it
  property p_osc7;
    osc_in_schmitt_out && $past(osc_in_schmitt_out) |-> !pin_oe_out[7];
  endproperty
  a_osc7: assert property (p_osc7) else $error("pin 7 driven in rc mode");
  property p_osc6;
    osc_in_schmitt_out && $past(osc_in_schmitt_out) |-> pin_oe_out[6];
  endproperty
  a_osc6: assert property (p_osc6) else $error("pin 6 idle in rc mode");
endmodule : port_a_mux_chk
bind port_a_pin_function_mux port_a_mux_chk port_a_mux_chk_i (.sys_clk_in, .reset_in, .reg_read_in,
  .reg_rdata_out, .pin_drive_out, .pin_oe_out, .analog_route_out, .sr_latch_true_out_in,
  .sr_latch_true_en_in, .sr_latch_inverted_out_in, .sr_latch_inverted_en_in, .capture_compare_pwm_unit_5_capture_out,
  .timer_zero_ext_clock_out, .osc_in_schmitt_out, .quarter_rate_clock_out);
`default_nettype wire

// >>> port_a_board_model.sv
// board side of port a: resolves each pin level
// assumes the board source always drives, so no pin floats
`timescale 1ns/1ns
`default_nettype none
module port_a_board_model (
  input  wire logic [7:0] pin_drive_in,
  input  wire logic [7:0] pin_oe_in,
  input  wire logic [7:0] ext_level_in,
  output logic      [7:0] pin_level_out
);
  assign pin_level_out = (pin_oe_in & pin_drive_in) | (~pin_oe_in & ext_level_in);
endmodule : port_a_board_model
`default_nettype wire

// >>> port_a_pin_function_mux_tb_top.sv
// self-checking bench for the port a pin multiplexer
// assumes the board model closes the pin loop
`timescale 1ns/1ns
`default_nettype none
module port_a_pin_function_mux_tb_top;
  typedef struct packed {logic [7:0] dir, ans, lat, ext, oe, drv, rd, rt;} row_t;
  logic        sys_clk_in, reset_in, wr_s, rd_s, cap, t0, ss, eck, sch, qck;
  logic [2:0]  adr;
  logic [7:0]  wd, rdat, drv, oe, rt, ext, lvl, got, cnt;
  logic [10:0] per;
  int          n_errors = 0;
  int          n_compared = 0;
  row_t        rows [5] = '{'{8'h00, 8'h2F, 8'h5A, 8'h00, 8'hFF, 8'h5A, 8'h00, 8'h00},
    '{8'hFF, 8'h00, 8'h00, 8'hC3, 8'h00, 8'h00, 8'hC3, 8'h00},
    '{8'hFF, 8'h2F, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hD0, 8'h2F},
    '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hD0, 8'h2F},
    '{8'h0F, 8'h00, 8'hF5, 8'h00, 8'hF0, 8'hF0, 8'h00, 8'h00}};
  logic [7:0]  rv [8] = '{8'h00, 8'hFF, 8'h2F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [10:0] pri [6] = '{11'h003, 11'h083, 11'h08F, 11'h300, 11'h320, 11'h230};
  logic [7:0]  pexp [6] = '{8'h10, 8'h00, 8'h10, 8'h20, 8'h00, 8'h20};
  logic [7:0]  mt [5][4] = '{'{8'h01, 8'h40, 8'h01, 8'h01}, '{8'h02, 8'h00, 8'h00, 8'h01},
    '{8'h03, 8'h00, 8'h00, 8'h01}, '{8'h04, 8'h80, 8'h00, 8'h00}, '{8'h00, 8'hC0, 8'h00, 8'h00}};
  port_a_pin_function_mux port_a_pin_function_mux_i (.sys_clk_in, .reset_in, .reg_addr_in(adr),
    .reg_wdata_in(wd), .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdat), .pin_level_in(lvl),
    .pin_drive_out(drv), .pin_oe_out(oe), .analog_route_out(rt), .capture_compare_pwm_unit_5_out_in(per[0]),
    .capture_compare_pwm_unit_5_out_en_in(per[1]), .capture_compare_pwm_unit_5_capture_out(cap), .sr_latch_true_out_in(per[2]),
    .sr_latch_true_en_in(per[3]), .sr_latch_inverted_out_in(per[4]), .sr_latch_inverted_en_in(per[5]),
    .comparator_one_output_in(per[6]), .comparator_one_en_in(per[7]), .comparator_two_output_in(per[8]),
    .comparator_two_en_in(per[9]), .dac_reference_output_en_in(per[10]), .timer_zero_ext_clock_out(t0),
    .serial_port_one_slave_select_out(ss), .external_clock_input_out(eck), .osc_in_schmitt_out(sch),
    .quarter_rate_clock_out(qck));
  port_a_board_model port_a_board_model_i (.pin_drive_in(drv), .pin_oe_in(oe), .ext_level_in(ext),
    .pin_level_out(lvl));
  task automatic chk8(input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    {adr, wd, wr_s} <= {a, d, 1'b1};
    @(posedge sys_clk_in);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk_in);
    {adr, rd_s} <= {a, 1'b1};
    @(posedge sys_clk_in);
    rd_s <= 1'b0;
    #1 got = rdat;
  endtask : rd
  // output path 1 flop, input path 3 flops; 6 edges covers both
  task automatic settle;
    repeat (6) @(posedge sys_clk_in);
    #1;
  endtask : settle
  task automatic close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_errors++;
    close_out();
  end
  initial begin
    {reset_in, wr_s, rd_s, adr, wd, ext, per} = {1'b1, 32'h00000000};
    repeat (20) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    wr(3'h5, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      rd(3'(i));
      chk8(got, rv[i]);
    end
    foreach (rows[i]) begin
      wr(3'h1, rows[i].dir);
      wr(3'h2, rows[i].ans);
      wr(3'h0, rows[i].lat);
      ext <= rows[i].ext;
      settle();
      chk8(oe, rows[i].oe);
      chk8(drv & oe, rows[i].drv);
      chk8(rt, rows[i].rt);
      rd(3'h4);
      if (rows[i].dir == 8'hFF) chk8(got, rows[i].rd);
    end
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h00);
    foreach (pri[i]) begin
      @(posedge sys_clk_in) per <= pri[i];
      settle();
      chk8(drv & 8'h30, pexp[i]);
    end
    @(posedge sys_clk_in) per <= 11'h000;
    wr(3'h1, 8'hFF);
    for (int b = 1; b >= 0; b--) begin
      @(posedge sys_clk_in) ext <= {2'b00, b[0], b[0], 4'h0};
      settle();
      chk1(cap, b[0]);
      chk1(t0, b[0]);
      chk1(ss, b[0]);
    end
    wr(3'h2, 8'h24);
    per <= 11'h400;
    ext <= 8'hB4;
    settle();
    chk1(ss, 1'b0);
    rd(3'h4);
    chk8(got & 8'h04, 8'h00);
    wr(3'h1, 8'h00);
    settle();
    chk8(oe, 8'hFB);
    foreach (mt[i]) begin
      wr(3'h3, mt[i][0]);
      settle();
      chk8(oe & 8'hC0, mt[i][1]);
      chk1(sch, mt[i][2][0]);
      chk1(eck, mt[i][3][0]);
      if (mt[i][0] == 8'h01) begin
        cnt = 8'h00;
        repeat (4) begin
          @(posedge sys_clk_in);
          #1 cnt = cnt + {7'h00, drv[6]} + {7'h00, qck};
        end
        chk8(cnt, 8'h04);
      end
    end
    @(posedge sys_clk_in) reset_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd(3'h1);
    chk8(got, 8'hFF);
    close_out();
  end
endmodule : port_a_pin_function_mux_tb_top
`default_nettype wire
